// >>> rtl/iss_sequencer.v
`timescale 1ns/10ps
`default_nettype none
`include "iss_defines.vh"

// Overview of operation
// - Static mode, outside mask edit: up button steps to next enabled screen.
// - Static mode, outside mask edit: down button steps to previous enabled screen.
// - Stepping wraps circularly at both ends of the screen list.
// - Screens with cleared enable bit are skipped in all stepping.
// - Screen one enable bit is always set; masking it does nothing.
// - Display mode static or dynamic; static after reset.
// - Dynamic mode holds each screen 1 to 3600 seconds, then advances.
// - Six-bit screen mask, all set after initialisation.
// - In mask edit, right toggles selected bit; confirm commits to storage.
// - Operating brightness is 8 bits, default 127.
// - Saver mode: disabled, low brightness, scrolling, off; scrolling default.
// - Saver starts after programmable idle seconds since last input or reset.
// - Any input restores brightness, ends saver, clears idle timer.
// - Saver idle timeout defaults to 900 seconds.
// - Saver brightness, 127 levels, used only in low brightness saver.
// - Settings changed during a saver episode apply from next activation.
// - Scrolling saver keeps normal operating brightness.
module iss_sequencer (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire clk_en_i,
    input wire btn_up_i,
    input wire down_button_i,
    input wire btn_right_i,
    input wire confirm_button_i,
    input wire btn_esc_i,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hsel,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output reg [`ISS_SCR_W-1:0] process_info_screen_o,
    output reg [7:0] disp_bright_o,
    output reg disp_blank_o,
    output reg disp_scroll_o,
    output reg saver_active_o
);

    // Last count of the one-second divider; the clock rate is fixed, so the
    // count is a sized constant rather than arithmetic on the clock rate.
    localparam [`ISS_TICK_W-1:0] TICK_MAX = `ISS_TICK_MAX;

    // Next enabled screen forward or backward, wrapping around.
    function [`ISS_SCR_W-1:0] step_scr;
        input [`ISS_SCR_W-1:0] cur;
        input [`ISS_NSCR-1:0] msk;
        input dir_up;
        reg [`ISS_SCR_W-1:0] p;
        reg found;
        integer k;
        begin
            p = cur;
            step_scr = cur;
            found = 1'b0;
            for (k = 0; k < `ISS_NSCR; k = k + 1) begin
                if (dir_up) begin
                    p = (p == `ISS_SCR_LAST) ? `ISS_SCR_FIRST : p + 3'h1;
                end else begin
                    p = (p == `ISS_SCR_FIRST) ? `ISS_SCR_LAST : p - 3'h1;
                end
                if (!found && msk[p]) begin
                    step_scr = p;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // Rising edge detect of a synchronised button.
    function edge_of;
        input cur;
        input prev;
        begin
            edge_of = cur & ~prev;
        end
    endfunction

    // Button synchronisers: two flops, then the edge stage.
    // The buttons are asynchronous, so nothing but the second stage reads the first.
    // The edge stage resets low like a released button, so no false press follows reset.
    reg [4:0] sync1_q, sync2_q, prev_q;
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            prev_q <= 5'h00;
        end else if (clk_en_i) begin
            sync1_q <= {btn_esc_i, confirm_button_i, btn_right_i, down_button_i, btn_up_i};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    wire up_p = edge_of(sync2_q[0], prev_q[0]);
    wire dn_p = edge_of(sync2_q[1], prev_q[1]);
    wire rt_p = edge_of(sync2_q[2], prev_q[2]);
    wire cf_p = edge_of(sync2_q[3], prev_q[3]);
    wire esc_p = edge_of(sync2_q[4], prev_q[4]);
    wire any_p = up_p | dn_p | rt_p | cf_p | esc_p;

    // Settings registers.
    reg mode_q;
    reg edit_q;
    reg [11:0] cycle_q;
    reg [`ISS_NSCR-1:0] edit_mask_q;
    reg [7:0] bright_q;
    reg [1:0] ss_mode_q;
    reg [`ISS_SEC_W-1:0] ss_time_q;
    reg [6:0] ss_bright_q;
    reg [`ISS_SCR_W-1:0] sel_q;
    wire [`ISS_NSCR-1:0] live_mask;
    wire commit = edit_q & cf_p;

    iss_mask_store u_store (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .wr_i(commit),
        .wdata_i(edit_mask_q),
        .rdata_o(live_mask)
    );

    // AHB-Lite address phase capture.
    // The slave never stalls, so every accepted address phase is followed by a
    // data phase in the very next cycle.
    reg wr_pend_q, rd_pend_q;
    reg [7:0] addr_q;
    wire take = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (clk_en_i) begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            if (take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Register writes; edit buffer follows the stored mask outside editing.
    // A bus write that enters editing lands after the commit clear, so a write
    // in the same cycle as a confirm press keeps editing active.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q <= `ISS_MODE_STATIC;
            edit_q <= 1'b0;
            cycle_q <= `ISS_CYCLE_RST;
            edit_mask_q <= `ISS_MASK_ALL;
            bright_q <= `ISS_BRIGHT_RST;
            ss_mode_q <= `ISS_SS_SCROLL;
            ss_time_q <= `ISS_SSTIME_RST;
            ss_bright_q <= `ISS_SSB_RST;
            sel_q <= `ISS_SCR_FIRST;
        end else if (clk_en_i) begin
            if (!edit_q) begin
                edit_mask_q <= live_mask;
            end else if (rt_p) begin
                edit_mask_q <= (edit_mask_q ^ (6'h01 << sel_q)) | `ISS_MASK_FIRST;
            end
            if (edit_q && up_p) begin
                sel_q <= (sel_q == `ISS_SCR_LAST) ? `ISS_SCR_FIRST : sel_q + 3'h1;
            end else if (edit_q && dn_p) begin
                sel_q <= (sel_q == `ISS_SCR_FIRST) ? `ISS_SCR_LAST : sel_q - 3'h1;
            end
            if (commit) begin
                edit_q <= 1'b0;
            end
            if (wr_pend_q) begin
                case (addr_q)
                    `ISS_A_CTRL: begin
                        mode_q <= hwdata[0];
                        if (hwdata[1]) begin
                            edit_q <= 1'b1;
                            sel_q <= `ISS_SCR_FIRST;
                        end
                    end
                    `ISS_A_CYCLE: begin
                        if (hwdata[11:0] < `ISS_CYCLE_MIN) begin
                            cycle_q <= `ISS_CYCLE_MIN;
                        end else if (hwdata[11:0] > `ISS_CYCLE_MAX || hwdata[31:12] != 20'h00000) begin
                            cycle_q <= `ISS_CYCLE_MAX;
                        end else begin
                            cycle_q <= hwdata[11:0];
                        end
                    end
                    `ISS_A_MASK: begin
                        if (edit_q) begin
                            edit_mask_q <= hwdata[5:0] | `ISS_MASK_FIRST;
                        end
                    end
                    `ISS_A_BRIGHT: bright_q <= hwdata[7:0];
                    `ISS_A_SAVER: ss_mode_q <= hwdata[1:0];
                    `ISS_A_SSTIME: ss_time_q <= hwdata[15:0];
                    `ISS_A_SSBRIGHT: begin
                        ss_bright_q <= (hwdata[6:0] > `ISS_SSB_MAX) ? `ISS_SSB_MAX : hwdata[6:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // One-second tick from the system clock.
    // The tick is a one-cycle strobe that both second counters share.
    reg [`ISS_TICK_W-1:0] tick_cnt_q;
    reg sec_q;
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt_q <= {`ISS_TICK_W{1'b0}};
            sec_q <= 1'b0;
        end else if (clk_en_i) begin
            sec_q <= (tick_cnt_q == TICK_MAX);
            tick_cnt_q <= (tick_cnt_q == TICK_MAX) ? {`ISS_TICK_W{1'b0}} : tick_cnt_q + 28'h0000001;
        end
    end

    // Screen stepping: manual in static mode, timed in dynamic mode.
    // A screen that loses its enable bit is left at once for the next enabled one,
    // so the display never rests on a masked screen.
    reg [11:0] dwell_q;
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            process_info_screen_o <= `ISS_SCR_FIRST;
            dwell_q <= 12'h000;
        end else if (clk_en_i) begin
            if (!live_mask[process_info_screen_o]) begin
                process_info_screen_o <= step_scr(process_info_screen_o, live_mask, 1'b1);
                dwell_q <= 12'h000;
            end else if (mode_q == `ISS_MODE_STATIC) begin
                dwell_q <= 12'h000;
                if (!edit_q && up_p) begin
                    process_info_screen_o <= step_scr(process_info_screen_o, live_mask, 1'b1);
                end else if (!edit_q && dn_p) begin
                    process_info_screen_o <= step_scr(process_info_screen_o, live_mask, 1'b0);
                end
            end else if (sec_q) begin
                if (dwell_q + 12'h001 >= cycle_q) begin
                    dwell_q <= 12'h000;
                    process_info_screen_o <= step_scr(process_info_screen_o, live_mask, 1'b1);
                end else begin
                    dwell_q <= dwell_q + 12'h001;
                end
            end
        end
    end

    // Screensaver: idle count, latched episode settings, wake on input.
    // An input in the same cycle as the timeout wins: the timer restarts instead.
    // Mode and level are copied at activation so an episode keeps its own look.
    reg [`ISS_SEC_W-1:0] idle_q;
    reg [1:0] ep_mode_q;
    reg [6:0] ep_bright_q;
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idle_q <= {`ISS_SEC_W{1'b0}};
            saver_active_o <= 1'b0;
            ep_mode_q <= `ISS_SS_SCROLL;
            ep_bright_q <= `ISS_SSB_RST;
        end else if (clk_en_i) begin
            if (any_p) begin
                idle_q <= {`ISS_SEC_W{1'b0}};
                saver_active_o <= 1'b0;
            end else if (!saver_active_o) begin
                if (ss_mode_q != `ISS_SS_OFF && idle_q >= ss_time_q) begin
                    saver_active_o <= 1'b1;
                    ep_mode_q <= ss_mode_q;
                    ep_bright_q <= ss_bright_q;
                end else if (sec_q && idle_q != 16'hFFFF) begin
                    idle_q <= idle_q + 16'h0001;
                end
            end
        end
    end

    // Display drive derived from the episode settings.
    // The outputs follow the saver flag one cycle later.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            disp_bright_o <= `ISS_BRIGHT_RST;
            disp_blank_o <= 1'b0;
            disp_scroll_o <= 1'b0;
        end else if (clk_en_i) begin
            disp_blank_o <= saver_active_o && ep_mode_q == `ISS_SS_BLANK;
            disp_scroll_o <= saver_active_o && ep_mode_q == `ISS_SS_SCROLL;
            if (saver_active_o && ep_mode_q == `ISS_SS_LOW) begin
                disp_bright_o <= {1'b0, ep_bright_q};
            end else if (saver_active_o && ep_mode_q == `ISS_SS_BLANK) begin
                disp_bright_o <= 8'h00;
            end else begin
                disp_bright_o <= bright_q;
            end
        end
    end

    // Read data in the data phase.
    // The word is captured at the address phase and stands until the next read.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata <= 32'h00000000;
        end else if (clk_en_i) begin
            if (take && !hwrite) begin
                case (haddr[7:0])
                    `ISS_A_CTRL: hrdata <= {30'h00000000, edit_q, mode_q};
                    `ISS_A_CYCLE: hrdata <= {20'h00000, cycle_q};
                    `ISS_A_MASK: hrdata <= {26'h0000000, edit_q ? edit_mask_q : live_mask};
                    `ISS_A_BRIGHT: hrdata <= {24'h000000, bright_q};
                    `ISS_A_SAVER: hrdata <= {30'h00000000, ss_mode_q};
                    `ISS_A_SSTIME: hrdata <= {16'h0000, ss_time_q};
                    `ISS_A_SSBRIGHT: hrdata <= {25'h0000000, ss_bright_q};
                    `ISS_A_STATUS: hrdata <= {1'b0, process_info_screen_o, 12'h000, idle_q[11:0], sel_q, saver_active_o};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // iss_sequencer
`default_nettype wire

// >>> include/iss_defines.vh
`ifndef ISS_DEFINES_VH
`define ISS_DEFINES_VH

// Clock rate and the one-second tick.
`define ISS_CLK_HZ 200000000
`define ISS_TICK_W 28
`define ISS_TICK_MAX 28'hBEBC1FF

// Bus register offsets, byte addresses.
`define ISS_A_CTRL 8'h00
`define ISS_A_CYCLE 8'h04
`define ISS_A_MASK 8'h08
`define ISS_A_BRIGHT 8'h0C
`define ISS_A_SAVER 8'h10
`define ISS_A_SSTIME 8'h14
`define ISS_A_SSBRIGHT 8'h18
`define ISS_A_STATUS 8'h1C

// Screen count and mask.
`define ISS_NSCR 6
`define ISS_SCR_W 3
`define ISS_SCR_LAST 3'h5
`define ISS_SCR_FIRST 3'h0
`define ISS_MASK_ALL 6'h3F
`define ISS_MASK_FIRST 6'h01

// Display modes.
`define ISS_MODE_STATIC 1'b0
`define ISS_MODE_DYNAMIC 1'b1

// Screensaver modes.
`define ISS_SS_OFF 2'h0
`define ISS_SS_LOW 2'h1
`define ISS_SS_SCROLL 2'h2
`define ISS_SS_BLANK 2'h3

// Reset values and limits.
`define ISS_CYCLE_RST 12'h001
`define ISS_CYCLE_MIN 12'h001
`define ISS_CYCLE_MAX 12'hE10
`define ISS_BRIGHT_RST 8'h7F
`define ISS_SSB_RST 7'h3F
`define ISS_SSB_MAX 7'h7E
`define ISS_SSTIME_RST 16'h0384
`define ISS_SEC_W 16

`endif

// >>> rtl/iss_mask_store.v
`timescale 1ns/10ps
`default_nettype none
`include "iss_defines.vh"

// Register image of the screen mask, all set by reset; committed words only, registered read.
module iss_mask_store (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire clk_en_i,
    input wire wr_i,
    input wire [`ISS_NSCR-1:0] wdata_i,
    output reg [`ISS_NSCR-1:0] rdata_o
);

    reg [`ISS_NSCR-1:0] mem_q;

    // Stored mask starts all enabled; screen one is always kept set.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_q <= `ISS_MASK_ALL;
            rdata_o <= `ISS_MASK_ALL;
        end else if (clk_en_i) begin
            if (wr_i) begin
                mem_q <= wdata_i | `ISS_MASK_FIRST;
            end
            rdata_o <= mem_q;
        end
    end

endmodule // iss_mask_store
`default_nettype wire

// >>> sim/iss_sequencer_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the display sequencer at its ports.
module iss_sequencer_sva (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic btn_esc_i,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [2:0] process_info_screen_o,
    input wire logic [7:0] disp_bright_o,
    input wire logic disp_blank_o,
    input wire logic disp_scroll_o,
    input wire logic saver_active_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // The slave never stalls and never reports an error.
    resp_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
    ready_high_a: assert property (hreadyout == 1'b1) else $error("bus ready dropped");
    // Only six screens exist.
    screen_range_a: assert property (process_info_screen_o <= 3'h5) else $error("screen out of range");
    // Leaving reset shows the first screen at default brightness, saver off.
    reset_state_a: assert property ($rose(resetn_i) |-> process_info_screen_o == 3'h0
        && disp_bright_o == 8'h7F && !saver_active_o) else $error("wrong state after reset");
    // Read data holds unless a read address phase came before.
    rdata_hold_a: assert property (clk_en_i && !$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata))
        else $error("read data moved");
    // An escape press ends the saver within a few cycles.
    esc_wake_a: assert property ($rose(btn_esc_i) |-> ##[1:8] !saver_active_o) else $error("saver kept");
    // Blanking and scrolling follow an active saver, one cycle behind its flag.
    blank_saver_a: assert property (disp_blank_o |-> $past(saver_active_o) && !disp_scroll_o)
        else $error("blank outside saver");
    scroll_saver_a: assert property (disp_scroll_o |-> $past(saver_active_o)) else $error("scroll outside saver");
    awake_lit_a: assert property (!$past(saver_active_o) |-> !disp_blank_o && !disp_scroll_o)
        else $error("saver look while awake");
    // The low saver level has 127 steps, 0 to 126.
    low_level_a: assert property ($past(saver_active_o) && !disp_blank_o && !disp_scroll_o
        |-> disp_bright_o <= 8'h7E) else $error("saver level too high");
    screen_step_c: cover property ($changed(process_info_screen_o));
    bus_read_c: cover property (hsel && htrans[1] && !hwrite);
    esc_press_c: cover property ($rose(btn_esc_i));
    saver_on_c: cover property ($rose(saver_active_o));
endmodule // iss_sequencer_sva
bind iss_sequencer iss_sequencer_sva i_sva (.sys_clk_i, .resetn_i, .clk_en_i, .btn_esc_i, .hsel, .htrans,
    .hwrite, .hrdata, .hreadyout, .hresp, .process_info_screen_o, .disp_bright_o, .disp_blank_o,
    .disp_scroll_o, .saver_active_o);
`default_nettype wire

// >>> sim/iss_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
// Joystick and escape buttons: one request is held for hold plus one cycles, then released for hold minus one.
module iss_panel_model (
    input wire logic clk_i,
    input wire logic [4:0] req_i,
    input wire logic [3:0] hold_i,
    output logic busy_o,
    output logic [4:0] btn_o
);
    logic [4:0] cnt_q;
    logic [3:0] hold_q;
    initial begin
        cnt_q = 5'h00;
        hold_q = 4'h0;
        btn_o = 5'h00;
    end
    // Press, hold, release; a released button reads low.
    always @(posedge clk_i) begin
        if (cnt_q == 5'h00 && req_i != 5'h00) begin
            btn_o <= req_i;
            hold_q <= hold_i;
            cnt_q <= {hold_i, 1'b0};
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q == {1'b0, hold_q}) btn_o <= 5'h00;
        end
    end
    assign busy_o = (cnt_q != 5'h00);
endmodule // iss_panel_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "iss_defines.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, clk_en_i = 1'b1, hwrite = 1'b0, hsel = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, process_info_screen_o, exp_s = 3'h0;
    logic [4:0] req = 5'h00, btn;
    logic [3:0] hold = 4'h4;
    logic [7:0] disp_bright_o;
    logic [5:0] msk = 6'h3F;
    logic hreadyout, hresp, busy, disp_blank_o, disp_scroll_o, saver_active_o;
    integer seed = 32'h2705076b, fail_count = 0, comparisons = 0, cycles = 0, i;
    iss_sequencer i_iss_sequencer (.sys_clk_i, .resetn_i, .clk_en_i, .btn_up_i(btn[0]), .down_button_i(btn[1]),
        .btn_right_i(btn[2]), .confirm_button_i(btn[3]), .btn_esc_i(btn[4]), .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hsel, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .process_info_screen_o,
        .disp_bright_o, .disp_blank_o, .disp_scroll_o, .saver_active_o);
    iss_panel_model i_iss_panel_model (.clk_i(sys_clk_i), .req_i(req), .hold_i(hold), .busy_o(busy), .btn_o(btn));
    // Free-running clock.
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    // Prints the counts and the verdict, then stops.
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            report_and_stop;
        end
    end
    // Next enabled screen in either direction, wrapping at both ends.
    function automatic logic [2:0] next_scr(input logic [2:0] c, input logic [5:0] m, input logic up);
        logic [2:0] n;
        n = c;
        for (int k = 0; k < 6; k++) begin
            n = up ? ((n == 3'h5) ? 3'h0 : n + 3'h1) : ((n == 3'h0) ? 3'h5 : n - 3'h1);
            if (m[n]) return n;
        end
        return c;
    endfunction
    // One single AHB-Lite word transfer; waits on ready in both phases.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge sys_clk_i);
        while (hreadyout !== 1'b1) @(posedge sys_clk_i);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk_i);
        while (hreadyout !== 1'b1) @(posedge sys_clk_i);
        rd = hrdata;
    endtask
    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    // One button press of random length, then the release.
    task automatic press(input logic [4:0] b);
        @(posedge sys_clk_i);
        req <= b;
        hold <= 4'h3 + 4'({$random(seed)} % 6);
        @(posedge sys_clk_i);
        req <= 5'h00;
        @(posedge sys_clk_i);
        while (busy) @(posedge sys_clk_i);
        repeat (3) @(posedge sys_clk_i);
    endtask
    // Random up and down presses, the first always down from where we stand.
    task automatic step_run(input int n);
        logic up;
        for (int k = 0; k < n; k++) begin
            r = $random(seed);
            up = (k != 0) && r[4];
            press(up ? 5'h01 : 5'h02);
            exp_s = next_scr(exp_s, msk, up);
            `CHK("screen", exp_s, process_info_screen_o)
        end
    endtask
    // Main sequence.
    initial begin
        repeat (4) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        chk_rd("ctrl", `ISS_A_CTRL, 32'h0);
        chk_rd("mask", `ISS_A_MASK, 32'h3F);
        chk_rd("bright", `ISS_A_BRIGHT, 32'h7F);
        chk_rd("saver", `ISS_A_SAVER, 32'h2);
        chk_rd("sstime", `ISS_A_SSTIME, 32'h384);
        chk_rd("unmapped", 8'h20, 32'h0);
        `CHK("screen", 3'h0, process_info_screen_o)
        bus(1'b1, `ISS_A_CYCLE, 32'h0);
        chk_rd("cycle low", `ISS_A_CYCLE, 32'h1);
        bus(1'b1, `ISS_A_CYCLE, 32'hFFF);
        chk_rd("cycle high", `ISS_A_CYCLE, 32'hE10);
        bus(1'b1, `ISS_A_SSBRIGHT, 32'h7F);
        chk_rd("saver level", `ISS_A_SSBRIGHT, 32'h7E);
        for (i = 3; i >= 0; i--) begin
            bus(1'b1, `ISS_A_SAVER, i);
            chk_rd("saver mode", `ISS_A_SAVER, i);
        end
        for (i = 0; i < 4; i++) begin
            r = (i == 0) ? 32'h0 : (i == 1) ? 32'hFF : $random(seed);
            bus(1'b1, `ISS_A_BRIGHT, r);
            repeat (3) @(negedge sys_clk_i);
            `CHK("bright out", r[7:0], disp_bright_o)
        end
        step_run(12);
        bus(1'b1, `ISS_A_CTRL, 32'h2);
        bus(1'b1, `ISS_A_MASK, 32'h2A);
        chk_rd("mask edit", `ISS_A_MASK, 32'h2B);
        press(5'h01);
        press(5'h04);
        chk_rd("mask toggled", `ISS_A_MASK, 32'h29);
        `CHK("screen in edit", exp_s, process_info_screen_o)
        press(5'h08);
        chk_rd("edit left", `ISS_A_CTRL, 32'h0);
        chk_rd("mask kept", `ISS_A_MASK, 32'h29);
        bus(1'b1, `ISS_A_MASK, 32'h1);
        chk_rd("mask locked", `ISS_A_MASK, 32'h29);
        msk = 6'h29;
        step_run(12);
        clk_en_i <= 1'b0;
        press(5'h01);
        `CHK("frozen screen", exp_s, process_info_screen_o)
        clk_en_i <= 1'b1;
        bus(1'b1, `ISS_A_CTRL, 32'h1);
        chk_rd("dynamic", `ISS_A_CTRL, 32'h1);
        bus(1'b1, `ISS_A_SSTIME, 32'h0);
        repeat (3) @(negedge sys_clk_i);
        `CHK("saver disabled", 1'b0, saver_active_o)
        bus(1'b1, `ISS_A_SSBRIGHT, 32'h21);
        bus(1'b1, `ISS_A_SAVER, 32'h1);
        repeat (3) @(negedge sys_clk_i);
        `CHK("saver on", 1'b1, saver_active_o)
        `CHK("saver level", 8'h21, disp_bright_o)
        bus(1'b1, `ISS_A_SAVER, 32'h3);
        bus(1'b1, `ISS_A_BRIGHT, 32'h5A);
        repeat (3) @(negedge sys_clk_i);
        `CHK("episode kept", 8'h21, disp_bright_o)
        press(5'h10);
        `CHK("blank on", 1'b1, disp_blank_o)
        `CHK("blank level", 8'h00, disp_bright_o)
        bus(1'b1, `ISS_A_SAVER, 32'h2);
        press(5'h10);
        `CHK("scroll on", 1'b1, disp_scroll_o)
        `CHK("scroll level", 8'h5A, disp_bright_o)
        bus(1'b1, `ISS_A_SAVER, 32'h0);
        press(5'h10);
        `CHK("saver after esc", 1'b0, saver_active_o)
        `CHK("bright restored", 8'h5A, disp_bright_o)
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
